// ### rtl/ftp_pkg.sv
// package: register map, field layout, timing constants and carrier types of the fast pwm timer
// Summary of operation
// (RULE1) counter equal to channel A compare sets compare_a_flag, flag bit 6.
// (RULE2) counter equal to channel B compare sets compare_b_flag, flag bit 5.
// (RULE3) entering a flag's interrupt vector clears that flag automatically.
// (RULE4) writing one to a flag bit clears it one cycle later; zero does nothing.
// (RULE5) interrupt request only when global enable, source enable and flag all set.
// (RULE6) in normal mode counter overflow sets overflow_flag, bit 2.
// (RULE7) in pwm mode a period match sets overflow_flag after delay; counter restarts.
// (RULE8) clearing through clear_on_period_match is no overflow and sets no flag.
// (RULE9) flag bits 7 and 0, pll register bits 6 to 3 read zero.
// (RULE10) fast clock runs full rate; low_speed_select bit 7 halves it.
// (RULE11) software should stop the timer before changing low_speed_select.
// (RULE12) fast_clock_select bit 2 picks fast clock, else system clock, for counter.
// (RULE13) fast_clock_select can only be set while pll_enable is one.
// (RULE14) pll_enable starts the pll; reads one when pll drives the system clock.
// (RULE15) lock indicator bit 0 reads one about 100 us after pll enable.
// (RULE16) software enables pll, waits, polls lock, then sets fast_clock_select.
// (RULE17) pwm counter counts 0 to period then wraps; frequency clock/(period+1).
// (RULE18) each channel drives true and inverted complement with no dead time.
// (RULE19) output modes: 00 off, 01 clear/set with complement, 10 no complement, 11 inverted.
// (RULE20) pwm compare writes go to a buffer copied at period match.
// (RULE21) reading a compare with a pending write returns the buffer.
// (RULE22) compare of zero or period holds the output at a constant level.
// (RULE23) pwm enable resets the counter on the cycle after a period match.
// (RULE24) fast domain events pass a synchronising stage before setting flags.
package ftp_pkg;

  // ---------------------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [5:0] IDX_PLL_CTRL   = 6'h27;
  localparam logic [5:0] IDX_CONTROL    = 6'h30;
  localparam logic [5:0] IDX_COUNTER    = 6'h2F;
  localparam logic [5:0] IDX_COMPARE_A  = 6'h2E;
  localparam logic [5:0] IDX_COMPARE_B  = 6'h2B;
  localparam logic [5:0] IDX_PERIOD     = 6'h2D;
  localparam logic [5:0] IDX_FLAGS      = 6'h38;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h39;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int CMP_A_BIT    = 6;
  localparam int CMP_B_BIT    = 5;
  localparam int OVF_BIT      = 2;
  localparam int LSM_BIT      = 7;
  localparam int FCS_BIT      = 2;
  localparam int PLL_ENABLE_BIT     = 1;
  localparam int LOCK_BIT     = 0;
  localparam int CTC_BIT      = 7;
  localparam int PWM_A_BIT    = 6;
  localparam int MODE_A_LSB   = 4;
  localparam int PWM_B_BIT    = 3;
  localparam int MODE_B_LSB   = 1;
  localparam int RUN_BIT      = 0;
  localparam logic [7:0] FLAG_MASK = 8'h64;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int PLL_LOCK_TIME_US = 100;
  localparam int CLK_HZ           = 50_000_000;
  localparam logic [15:0] PLL_LOCK_CYCLES = 16'(PLL_LOCK_TIME_US * (CLK_HZ / 1_000_000));

  // ---------------------------------------------------------------------------
  // output modes and carriers
  // ---------------------------------------------------------------------------
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_PAIR = 2'h1;
  localparam logic [1:0] MODE_TRUE = 2'h2;
  localparam logic [1:0] MODE_INV  = 2'h3;

  typedef struct packed {
    logic true_out;
    logic true_oe;
    logic comp_out;
    logic comp_oe;
  } ftp_chan_pins_t;

  typedef struct packed {
    ftp_chan_pins_t a;
    ftp_chan_pins_t b;
  } ftp_pwm_pins_t;

  typedef struct packed {
    logic compare_a;
    logic compare_b;
    logic overflow;
  } ftp_irq_t;

endpackage : ftp_pkg

// ### rtl/ftp_timer.sv
// module: 8-bit pwm timer with flags, double buffered compares and pll clock control
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ns
module ftp_timer #(
  parameter logic [15:0] LOCK_CYCLES = ftp_pkg::PLL_LOCK_CYCLES  // pll lock wait in clk cycles
) (
  input  wire logic              clk,           // system clock, 50 MHz
  input  wire logic              rst_n,         // synchronous reset, active low
  input  wire logic              wb_cyc_i,      // wishbone cycle
  input  wire logic              wb_stb_i,      // wishbone strobe
  input  wire logic              wb_we_i,       // wishbone write enable
  input  wire logic [7:0]        wb_adr_i,      // wishbone byte address
  input  wire logic [3:0]        wb_sel_i,      // wishbone byte lanes
  input  wire logic [31:0]       wb_dat_i,      // wishbone write data
  output logic      [31:0]       wb_dat_o,      // wishbone read data
  output logic                   wb_ack_o,      // wishbone acknowledge
  input  wire logic              global_irq_en, // global interrupt enable of the processor
  input  wire ftp_pkg::ftp_irq_t vector_ack,    // pulse: processor entered that vector
  input  wire logic              pll_sysclk_pin,// strap: pll is the system clock source
  output ftp_pkg::ftp_irq_t      irq_req,       // interrupt requests
  output ftp_pkg::ftp_pwm_pins_t pwm_pins       // channel outputs and enables
);
  import ftp_pkg::*;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]    control;
    logic [7:0]    counter;
    logic [7:0]    cmp_a;
    logic [7:0]    cmp_b;
    logic [7:0]    buf_a;
    logic [7:0]    buf_b;
    logic          pend_a;
    logic          pend_b;
    logic [7:0]    period;
    logic [7:0]    flags;
    logic [7:0]    ev_sync;
    logic [7:0]    clr_pend;
    logic [7:0]    irq_en;
    logic          low_speed_select;
    logic          fcs;
    logic          pll_enable;
    logic          lock;
    logic [15:0]   lock_cnt;
    logic          fdiv;
    logic          strap_m;
    logic          strap_s;
    logic [31:0]   dat;
    logic          ack;
    ftp_irq_t      irq;
    ftp_pwm_pins_t pins;
  } ftp_state_t;

  ftp_state_t s_q;
  ftp_state_t s_d;

  // ---------------------------------------------------------------------------
  // pwm level of the true output after the counter moves to cnt
  // ---------------------------------------------------------------------------
  function automatic logic pwm_level(input logic [1:0] mode, input logic [7:0] cnt,
                                     input logic [7:0] cmp, input logic [7:0] per,
                                     input logic cur);
    logic inv;
    inv = (mode == MODE_INV);
    if (cmp == 8'h00) begin
      pwm_level = inv;                                  // RULE22
    end else if (cmp == per) begin
      pwm_level = !inv;                                 // RULE22
    end else if (cnt == cmp) begin
      pwm_level = inv;                                  // RULE19
    end else if (cnt == 8'h01) begin
      pwm_level = !inv;                                 // RULE19
    end else begin
      pwm_level = cur;
    end
  endfunction : pwm_level

  // next pin group of one channel
  function automatic ftp_chan_pins_t chan_pins(input logic en, input logic [1:0] mode,
                                               input logic lvl);
    chan_pins.true_out = lvl;
    chan_pins.comp_out = !lvl;                          // RULE18
    chan_pins.true_oe  = en && (mode != MODE_OFF);      // RULE19
    chan_pins.comp_oe  = en && (mode == MODE_PAIR);     // RULE19
  endfunction : chan_pins

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic       pwm;
    logic       tick;
    logic       hit;
    logic       wr;
    logic       pll_on;
    logic [7:0] ev;
    logic [7:0] cnt_n;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] mode_a;
    logic [1:0] mode_b;
    logic       lvl_a;
    logic       lvl_b;
    s_d    = s_q;
    ev     = 8'h00;
    rd     = 8'h00;
    wd     = wb_dat_i[7:0];
    mode_a = s_q.control[MODE_A_LSB +: 2];
    mode_b = s_q.control[MODE_B_LSB +: 2];
    pwm    = s_q.control[PWM_A_BIT] || s_q.control[PWM_B_BIT];
    hit    = wb_cyc_i && wb_stb_i && !s_q.ack;
    wr     = hit && wb_we_i && wb_sel_i[0];
    pll_on = s_q.pll_enable || s_q.strap_s;                   // RULE14

    s_d.strap_m = pll_sysclk_pin;
    s_d.strap_s = s_q.strap_m;

    // fast clock modelled as an enable; low speed takes every second cycle
    s_d.fdiv = s_q.fcs && s_q.low_speed_select && !s_q.fdiv;         // RULE10
    tick = s_q.control[RUN_BIT] && (!s_q.fcs || !s_q.low_speed_select || s_q.fdiv); // RULE12

    // counter
    cnt_n = s_q.counter;
    if (tick) begin
      if (pwm) begin
        if (s_q.counter == s_q.period) begin
          cnt_n = 8'h00;                                // RULE23 RULE17
          ev[OVF_BIT] = 1'b1;                           // RULE7
          if (s_q.pend_a) begin
            s_d.cmp_a  = s_q.buf_a;                     // RULE20
            s_d.pend_a = 1'b0;
          end
          if (s_q.pend_b) begin
            s_d.cmp_b  = s_q.buf_b;                     // RULE20
            s_d.pend_b = 1'b0;
          end
        end else begin
          cnt_n = s_q.counter + 8'h01;
        end
      end else if (s_q.control[CTC_BIT] && s_q.counter == s_q.period) begin
        cnt_n = 8'h00;                                  // RULE8
      end else begin
        cnt_n = s_q.counter + 8'h01;
        ev[OVF_BIT] = (s_q.counter == 8'hFF);           // RULE6
      end
      ev[CMP_A_BIT] = (cnt_n == s_d.cmp_a);             // RULE1
      ev[CMP_B_BIT] = (cnt_n == s_d.cmp_b);             // RULE2
      s_d.counter = cnt_n;
    end

    // pwm outputs; outside pwm mode the pins are released
    lvl_a = pwm_level(mode_a, cnt_n, s_d.cmp_a, s_q.period, s_q.pins.a.true_out);
    lvl_b = pwm_level(mode_b, cnt_n, s_d.cmp_b, s_q.period, s_q.pins.b.true_out);
    if (tick) begin
      s_d.pins.a = chan_pins(s_q.control[PWM_A_BIT], mode_a, lvl_a);
      s_d.pins.b = chan_pins(s_q.control[PWM_B_BIT], mode_b, lvl_b);
    end
    // keep the complement inverted even before the first tick, so an enable
    // written while stopped never drives both gates to the same level
    s_d.pins.a.comp_out = !s_d.pins.a.true_out;          // RULE18
    s_d.pins.b.comp_out = !s_d.pins.b.true_out;          // RULE18
    s_d.pins.a.true_oe = s_q.control[PWM_A_BIT] && (mode_a != MODE_OFF);
    s_d.pins.a.comp_oe = s_q.control[PWM_A_BIT] && (mode_a == MODE_PAIR);
    s_d.pins.b.true_oe = s_q.control[PWM_B_BIT] && (mode_b != MODE_OFF);
    s_d.pins.b.comp_oe = s_q.control[PWM_B_BIT] && (mode_b == MODE_PAIR);

    // events pass one synchronising stage; a set beats a clear in the same cycle
    s_d.ev_sync = ev & FLAG_MASK;                       // RULE24
    s_d.flags   = (s_q.flags & ~s_q.clr_pend                              // RULE4
                   & ~{1'b0, vector_ack.compare_a, vector_ack.compare_b,  // RULE3
                       2'b00, vector_ack.overflow, 2'b00})
                  | s_q.ev_sync;
    s_d.flags   = s_d.flags & FLAG_MASK;                // RULE9
    s_d.clr_pend = 8'h00;

    s_d.irq.compare_a = global_irq_en && s_q.irq_en[CMP_A_BIT] && s_q.flags[CMP_A_BIT]; // RULE5
    s_d.irq.compare_b = global_irq_en && s_q.irq_en[CMP_B_BIT] && s_q.flags[CMP_B_BIT]; // RULE5
    s_d.irq.overflow  = global_irq_en && s_q.irq_en[OVF_BIT] && s_q.flags[OVF_BIT];     // RULE5

    // pll lock timer restarts whenever the pll is switched off
    if (!pll_on) begin
      s_d.lock_cnt = 16'h0000;
      s_d.lock     = 1'b0;
    end else if (s_q.lock_cnt < LOCK_CYCLES - 16'h0001) begin
      s_d.lock_cnt = s_q.lock_cnt + 16'h0001;
    end else begin
      s_d.lock     = 1'b1;                              // RULE15
    end

    // register read mux
    unique case (wb_adr_i[7:2])
      IDX_PLL_CTRL:   rd = {s_q.low_speed_select, 4'h0, s_q.fcs, pll_on, s_q.lock}; // RULE9 RULE14
      IDX_CONTROL:    rd = s_q.control;
      IDX_COUNTER:    rd = s_q.counter;
      IDX_COMPARE_A:  rd = s_q.pend_a ? s_q.buf_a : s_q.cmp_a;       // RULE21
      IDX_COMPARE_B:  rd = s_q.pend_b ? s_q.buf_b : s_q.cmp_b;       // RULE21
      IDX_PERIOD:     rd = s_q.period;
      IDX_FLAGS:      rd = s_q.flags & FLAG_MASK;                    // RULE9
      IDX_IRQ_ENABLE: rd = s_q.irq_en;
      default:        rd = 8'h00;
    endcase

    // register writes take effect at the edge that raises ack
    if (wr) begin
      unique case (wb_adr_i[7:2])
        IDX_PLL_CTRL: begin
          s_d.low_speed_select  = wd[LSM_BIT];                       // RULE10
          s_d.pll_enable = wd[PLL_ENABLE_BIT];                      // RULE14
          s_d.fcs  = wd[FCS_BIT] && (wd[PLL_ENABLE_BIT] || s_q.strap_s); // RULE13 RULE12
        end
        IDX_CONTROL: s_d.control = wd;
        IDX_COUNTER: s_d.counter = wd;
        IDX_COMPARE_A: begin
          if (pwm) begin
            s_d.buf_a  = wd;                            // RULE20
            s_d.pend_a = 1'b1;
          end else begin
            s_d.cmp_a  = wd;
          end
        end
        IDX_COMPARE_B: begin
          if (pwm) begin
            s_d.buf_b  = wd;                            // RULE20
            s_d.pend_b = 1'b1;
          end else begin
            s_d.cmp_b  = wd;
          end
        end
        IDX_PERIOD:     s_d.period   = wd;
        IDX_FLAGS:      s_d.clr_pend = wd & FLAG_MASK;  // RULE4
        IDX_IRQ_ENABLE: s_d.irq_en   = wd & FLAG_MASK;
        default: ;
      endcase
    end

    s_d.ack = hit;
    s_d.dat = hit ? {24'h000000, rd} : 32'h00000000;
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.period   <= RST_PERIOD;
      s_q.control  <= RST_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign irq_req  = s_q.irq;
  assign pwm_pins = s_q.pins;

endmodule : ftp_timer

// ### bench/ftp_timer_properties.sv
// checker: port-level properties of the fast pwm timer
`timescale 1ns/1ns
module ftp_timer_properties
  import ftp_pkg::*;
(
  input wire logic                   clk,           // system clock
  input wire logic                   rst_n,         // sync reset
  input wire logic                   wb_cyc_i,      // bus cycle
  input wire logic                   wb_stb_i,      // bus strobe
  input wire logic                   wb_we_i,       // bus write
  input wire logic [7:0]             wb_adr_i,      // byte address
  input wire logic [31:0]            wb_dat_o,      // read data
  input wire logic                   wb_ack_o,      // acknowledge
  input wire logic                   global_irq_en, // processor enable
  input wire ftp_pkg::ftp_irq_t      irq_req,       // requests
  input wire ftp_pkg::ftp_pwm_pins_t pwm_pins       // pin drive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       rd_ack;
  logic [5:0] idx;
  assign rd_ack = wb_ack_o && !wb_we_i;
  assign idx = wb_adr_i[7:2];
  chk_ack_taken: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over two cycles");
  chk_flag_rsvd: assert property (
    rd_ack && idx == IDX_FLAGS |-> !wb_dat_o[7] && !wb_dat_o[0])
    else $error("flag reserved bit read as one");
  chk_pll_rsvd: assert property (
    rd_ack && idx == IDX_PLL_CTRL |-> wb_dat_o[6:3] == 4'h0)
    else $error("pll reserved bits read as one");
  chk_lock_pll: assert property (
    rd_ack && idx == IDX_PLL_CTRL && wb_dat_o[0] |-> wb_dat_o[1])
    else $error("lock shown with pll off");
  chk_irq_gated: assert property (|irq_req |-> $past(global_irq_en))
    else $error("request without global enable");
  chk_comp_inverse: assert property (
    (!pwm_pins.a.comp_oe || pwm_pins.a.comp_out != pwm_pins.a.true_out) &&
    (!pwm_pins.b.comp_oe || pwm_pins.b.comp_out != pwm_pins.b.true_out))
    else $error("complement equals true output");
  chk_comp_true: assert property (pwm_pins.a.comp_oe |-> pwm_pins.a.true_oe)
    else $error("complement driven without true output");
  cov_irq_a: cover property ($rose(irq_req.compare_a));
  cov_comp_on: cover property (pwm_pins.a.comp_oe);
  cov_lock: cover property (rd_ack && idx == IDX_PLL_CTRL && wb_dat_o[0]);
endmodule : ftp_timer_properties

bind ftp_timer ftp_timer_properties u_props (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .global_irq_en(global_irq_en), .irq_req(irq_req), .pwm_pins(pwm_pins));

// ### bench/ftp_pin_load.sv
// partner: gate loads on the true pins, counting pulses
`timescale 1ns/1ns
module ftp_pin_load
  import ftp_pkg::*;
(
  input wire logic                   clk,   // system clock
  input wire ftp_pkg::ftp_pwm_pins_t pins,  // block pin drive
  output logic [1:0]                 pad,   // gate level a, b
  output int                         rises  // rising edges on gate a
);
  initial pad = 2'h0;
  initial rises = 0;
  // an undriven gate floats: show the inverse of the last level
  always @(posedge clk) begin
    pad[1] <= pins.a.true_oe ? pins.a.true_out : ~pad[1];
    pad[0] <= pins.b.true_oe ? pins.b.true_out : ~pad[0];
    if (pins.a.true_oe && pins.a.true_out && !pad[1]) begin
      rises <= rises + 1;
    end
  end
endmodule : ftp_pin_load

// ### bench/ftp_timer_test.sv
// testbench: register-level scenarios of the fast pwm timer
`timescale 1ns/1ns
module ftp_timer_test;
  import ftp_pkg::*;
  logic          clk, rst_n, cyc, stb, we, gie, strap, ack;
  logic [7:0]    adr, q;
  logic [3:0]    sel;
  logic [31:0]   wdat, rdat;
  ftp_irq_t      vack, irq;
  ftp_pwm_pins_t pins;
  logic [1:0]    pad;
  int            rises, r0, errors, tests_run, k;
  logic [23:0]   tbl;
  ftp_timer #(.LOCK_CYCLES(16'h0014)) uut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .global_irq_en(gie), .vector_ack(vack), .pll_sysclk_pin(strap),
    .irq_req(irq), .pwm_pins(pins));
  ftp_pin_load load (.clk(clk), .pins(pins), .pad(pad), .rises(rises));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  task automatic stop_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // request held until ack is sampled, then released for a cycle
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {i, 2'h0};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 16);
    q = rdat[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
    if (n >= 16) begin
      errors++;
      stop_test();
    end
  endtask : bus
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    bus(1'h1, i, d);
  endtask : wr
  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    bus(1'h0, i, 8'h00);
    chk(q, e);
  endtask : rd
  // software waits the lock time, then polls
  task automatic lock_wait;
    repeat (20) @(posedge clk);
    k = 0;
    do begin
      bus(1'h0, IDX_PLL_CTRL, 8'h00);
      k++;
    end while (q[0] !== 1'h1 && k < 40);
    if (q[0] !== 1'h1) begin
      errors++;
      stop_test();
    end
  endtask : lock_wait
  task automatic span(input int c, input logic [7:0] e);
    r0 = rises;
    repeat (c) @(posedge clk);
    chk(8'(rises - r0), e);
  endtask : span
  initial begin
    {rst_n, cyc, stb, we, gie, strap, adr, wdat} = '0;
    vack = 3'h0;
    sel = 4'hF;
    errors = 0;
    tests_run = 0;
    tbl = 24'h5B8C98;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(IDX_PERIOD, RST_PERIOD);
    rd(IDX_FLAGS, RST_BYTE);
    rd(6'h01, 8'h00);
    wr(IDX_PLL_CTRL, 8'h04);
    rd(IDX_PLL_CTRL, 8'h00);
    wr(IDX_PLL_CTRL, 8'h02);
    lock_wait();
    rd(IDX_PLL_CTRL, 8'h03);
    wr(IDX_PLL_CTRL, 8'hFE);
    rd(IDX_PLL_CTRL, 8'h87);
    wr(IDX_PLL_CTRL, 8'h00);
    wr(IDX_COMPARE_A, 8'h01);
    wr(IDX_COMPARE_B, 8'h02);
    wr(IDX_COUNTER, 8'hFE);
    wr(IDX_CONTROL, 8'h01);
    repeat (6) @(posedge clk);
    wr(IDX_CONTROL, 8'h00);
    rd(IDX_FLAGS, 8'h64);
    wr(IDX_IRQ_ENABLE, 8'h40);
    repeat (3) @(posedge clk);
    chk({5'h0, irq}, 8'h00);
    gie <= 1'h1;
    repeat (3) @(posedge clk);
    chk({5'h0, irq}, 8'h04);
    vack <= 3'h4;
    @(posedge clk);
    vack <= 3'h0;
    repeat (3) @(posedge clk);
    chk({5'h0, irq}, 8'h00);
    rd(IDX_FLAGS, 8'h24);
    wr(IDX_FLAGS, 8'h20);
    rd(IDX_FLAGS, 8'h04);
    wr(IDX_FLAGS, 8'h04);
    rd(IDX_FLAGS, 8'h00);
    wr(IDX_PERIOD, 8'h05);
    wr(IDX_COUNTER, 8'h00);
    wr(IDX_CONTROL, 8'h81);
    repeat (20) @(posedge clk);
    wr(IDX_CONTROL, 8'h00);
    rd(IDX_FLAGS, 8'h60);
    wr(IDX_FLAGS, 8'h60);
    wr(IDX_PERIOD, 8'h09);
    wr(IDX_COMPARE_A, 8'h04);
    wr(IDX_CONTROL, 8'h51);
    repeat (12) @(posedge clk);
    span(100, 8'h0A);
    rd(IDX_FLAGS, 8'h64);
    wr(IDX_CONTROL, 8'h50);
    wr(IDX_COMPARE_A, 8'h07);
    rd(IDX_COMPARE_A, 8'h07);
    for (k = 0; k < 8; k++) begin
      wr(IDX_COMPARE_A, k[2] ? 8'h09 : 8'h00);
      wr(IDX_CONTROL, {2'h1, k[1:0], 4'h1});
      repeat (25) @(posedge clk);
      chk({5'h0, pins.a.true_out & pins.a.true_oe, pins.a.true_oe, pins.a.comp_oe},
          8'(tbl[3*k +: 3]));
    end
    wr(IDX_CONTROL, 8'h0B);
    repeat (25) @(posedge clk);
    chk({4'h0, pins.a.true_oe, pins.b.true_oe, pins.b.comp_oe, pins.b.comp_out ^ pins.b.true_out},
        8'h07);
    wr(IDX_COMPARE_A, 8'h04);
    wr(IDX_CONTROL, 8'h51);
    repeat (25) @(posedge clk);
    wr(IDX_CONTROL, 8'h50);
    wr(IDX_PLL_CTRL, 8'h02);
    lock_wait();
    wr(IDX_PLL_CTRL, 8'h86);
    wr(IDX_CONTROL, 8'h51);
    repeat (12) @(posedge clk);
    span(100, 8'h05);
    wr(IDX_CONTROL, 8'h50);
    wr(IDX_PLL_CTRL, 8'h00);
    strap <= 1'h1;
    repeat (40) @(posedge clk);
    rd(IDX_PLL_CTRL, 8'h03);
    stop_test();
  end
endmodule : ftp_timer_test
